// [common/sdcp_cfg.svh]
// Constants for the serial converter control port.
// Included by the package and by every design module.
`ifndef SDCP_CFG_SVH
`define SDCP_CFG_SVH
`define SDCP_FRAME_BITS    12
`define SDCP_CODE_BITS     10
`define SDCP_PIX_BITS      10
`define SDCP_SYNC_STAGES   3
`define SDCP_SEL_POS       10
`define SDCP_CODE_MSB      9
`define SDCP_CODE_LSB      0
`define SDCP_CODE_RESET    10'h000
`define SDCP_FRAME_RESET   12'h000
`define SDCP_SYNC_RESET    3'h0
`define SDCP_PIX_RESET     10'h000
`define SDCP_SEL_ATTEN     1'b0
`define SDCP_SEL_AUX       1'b1
`endif

// [common/sdcp_pkg.sv]
// Types shared by the serial converter control port modules.
// Assumes sdcp_cfg.svh is on the include path.
`include "sdcp_cfg.svh"
package sdcp_pkg;
    typedef logic [`SDCP_FRAME_BITS-1:0] sdcp_frame_t;
    typedef logic [`SDCP_CODE_BITS-1:0]  sdcp_code_t;
    typedef logic [`SDCP_PIX_BITS-1:0]   sdcp_pix_t;
endpackage

// [rtl/sdcp_sync.sv]
// Three-stage pin synchroniser with rise and fall detection.
// Assumes the input is asynchronous to clk_sys_in.
`timescale 1ns/1ps
`include "sdcp_cfg.svh"
module sdcp_sync
    import sdcp_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic reset_in,
    input  wire logic enable_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic [`SDCP_SYNC_STAGES-1:0] stage;
    logic [`SDCP_SYNC_STAGES-1:0] next_stage;
    logic                         level;
    logic                         next_level;

    // Level changes only when stages two and three agree
    always_comb begin
        next_stage = {stage[`SDCP_SYNC_STAGES-2:0], pin_in};
        next_level = level;
        if (stage[1] == stage[2]) begin
            next_level = stage[2];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            stage <= `SDCP_SYNC_RESET;
            level <= 1'b0;
        end else if (enable_in) begin
            stage <= next_stage;
            level <= next_level;
        end
    end

    assign level_out = level;
    assign rise_out  = enable_in & (stage[1] == stage[2]) & stage[2] & ~level;
    assign fall_out  = enable_in & (stage[1] == stage[2]) & ~stage[2] & level;
endmodule

// [rtl/sdcp_shift.sv]
// Twelve-stage master-slave shift register for the serial port.
// Assumes single-cycle clock-edge pulses from the synchronisers.
`timescale 1ns/1ps
`include "sdcp_cfg.svh"
module sdcp_shift
    import sdcp_pkg::*;
(
    input  wire logic  clk_sys_in,
    input  wire logic  clear_in,
    input  wire logic  enable_in,
    input  wire logic  data_in,
    input  wire logic  sclk_rise_in,
    input  wire logic  sclk_fall_in,
    output sdcp_frame_t frame_out
);
    sdcp_frame_t master;
    sdcp_frame_t slave;
    sdcp_frame_t next_master;
    sdcp_frame_t next_slave;

    always_comb begin
        next_master = master;
        next_slave  = slave;
        if (sclk_rise_in) begin
            // Master takes the slave chain shifted by one plus new bit
            next_master = {slave[`SDCP_FRAME_BITS-2:0], data_in};
        end
        if (sclk_fall_in) begin
            next_slave = master;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (clear_in) begin
            master <= `SDCP_FRAME_RESET;
            slave  <= `SDCP_FRAME_RESET;
        end else if (enable_in) begin
            master <= next_master;
            slave  <= next_slave;
        end
    end

    assign frame_out = slave;
endmodule

// [rtl/sdcp_top.sv]
// Serial converter control port with pixel timing capture.
// Assumes every pin input is asynchronous to clk_sys_in.
`timescale 1ns/1ps
`include "sdcp_cfg.svh"
module sdcp_top
    import sdcp_pkg::*;
(
    input  wire logic  clk_sys_in,
    input  wire logic  reset_in,
    input  wire logic  enable_in,
    input  wire logic  serial_data_in,
    input  wire logic  serial_clock_in,
    input  wire logic  write_strobe_in,
    input  wire logic  register_reset_n_in,
    input  wire logic  reference_sample_pulse_n_in,
    input  wire logic  pixel_sample_pulse_n_in,
    input  wire logic  dummy_clamp_pulse_n_in,
    input  wire logic  black_clamp_pulse_n_in,
    input  wire logic  output_latch_clock_in,
    input  sdcp_pix_t  pixel_word_in,
    output sdcp_code_t attenuation_converter_out,
    output sdcp_code_t auxiliary_converter_out,
    output logic       input_clamp_out,
    output logic       black_loop_enable_out,
    output logic       dummy_loop_enable_out,
    output logic       sample_reference_out,
    output logic       sample_pixel_out,
    output sdcp_pix_t  pixel_word_out
);
    localparam int NPIN = 9;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_rise;
    logic [NPIN-1:0] pin_fall;

    // Active-low pins inverted first so the cleared synchroniser matches idle
    assign pin_raw = {output_latch_clock_in, ~black_clamp_pulse_n_in,
                      ~dummy_clamp_pulse_n_in, ~pixel_sample_pulse_n_in,
                      ~reference_sample_pulse_n_in, ~register_reset_n_in,
                      write_strobe_in, serial_clock_in, serial_data_in};

    // One synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            sdcp_sync u_sync (
                .clk_sys_in (clk_sys_in),
                .reset_in   (reset_in),
                .enable_in  (enable_in),
                .pin_in     (pin_raw[gi]),
                .level_out  (pin_lvl[gi]),
                .rise_out   (pin_rise[gi]),
                .fall_out   (pin_fall[gi])
            );
        end
    endgenerate

    logic sd_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic wrt_rise;
    logic rst_active;
    logic ref_act;
    logic dat_act;
    logic dum_act;
    logic blk_act;
    logic output_latch_clock_rise;

    assign sd_lvl     = pin_lvl[0];
    assign sclk_rise  = pin_rise[1];
    assign sclk_fall  = pin_fall[1];
    assign wrt_rise   = pin_rise[2];
    // Pin reset acts on raw or synchronised level, serial clock edges or not
    assign rst_active = reset_in | ~register_reset_n_in | pin_lvl[3];
    assign ref_act    = pin_lvl[4];
    assign dat_act    = pin_lvl[5];
    assign dum_act    = pin_lvl[6];
    assign blk_act    = pin_lvl[7];
    assign output_latch_clock_rise  = pin_rise[8];

    sdcp_frame_t frame;

    // Reset pin is combined into the shift clear
    sdcp_shift u_shift (
        .clk_sys_in   (clk_sys_in),
        .clear_in     (rst_active),
        .enable_in    (enable_in),
        .data_in      (sd_lvl),
        .sclk_rise_in (sclk_rise),
        .sclk_fall_in (sclk_fall),
        .frame_out    (frame)
    );

    sdcp_code_t atten_code;
    sdcp_code_t aux_code;
    sdcp_code_t next_atten_code;
    sdcp_code_t next_aux_code;
    sdcp_code_t frame_code;
    logic       frame_sel;

    // Leading slot bit frame[11] is never looked at
    assign frame_sel  = frame[`SDCP_SEL_POS];
    assign frame_code = frame[`SDCP_CODE_MSB:`SDCP_CODE_LSB];

    always_comb begin
        next_atten_code = atten_code;
        next_aux_code   = aux_code;
        if (wrt_rise) begin
            unique case (frame_sel)
                `SDCP_SEL_ATTEN: next_atten_code = frame_code;
                `SDCP_SEL_AUX:   next_aux_code   = frame_code;
            endcase
        end
    end

    // Two independent holding registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_active) begin
            atten_code <= `SDCP_CODE_RESET;
            aux_code   <= `SDCP_CODE_RESET;
        end else if (enable_in) begin
            atten_code <= next_atten_code;
            aux_code   <= next_aux_code;
        end
    end

    // Code passed raw; analog side inverts, zero is highest voltage
    assign attenuation_converter_out = atten_code;
    assign auxiliary_converter_out   = aux_code;

    sdcp_pix_t pix;
    sdcp_pix_t next_pix;
    logic      clamp;
    logic      next_clamp;
    logic      blk_en;
    logic      next_blk_en;
    logic      dum_en;
    logic      next_dum_en;
    logic      smp_ref;
    logic      next_smp_ref;
    logic      smp_pix;
    logic      next_smp_pix;

    always_comb begin
        next_pix     = pix;
        if (output_latch_clock_rise) begin
            next_pix = pixel_word_in;
        end
        next_clamp   = ref_act & dum_act;
        next_blk_en  = blk_act;
        next_dum_en  = dum_act;
        next_smp_ref = ref_act;
        next_smp_pix = dat_act;
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            pix     <= `SDCP_PIX_RESET;
            clamp   <= 1'b0;
            blk_en  <= 1'b0;
            dum_en  <= 1'b0;
            smp_ref <= 1'b0;
            smp_pix <= 1'b0;
        end else if (enable_in) begin
            pix     <= next_pix;
            clamp   <= next_clamp;
            blk_en  <= next_blk_en;
            dum_en  <= next_dum_en;
            smp_ref <= next_smp_ref;
            smp_pix <= next_smp_pix;
        end
    end

    assign pixel_word_out        = pix;
    assign input_clamp_out       = clamp;
    assign black_loop_enable_out = blk_en;
    assign dummy_loop_enable_out = dum_en;
    assign sample_reference_out  = smp_ref;
    assign sample_pixel_out      = smp_pix;
endmodule

// [tb/sdcp_host_model.sv]
// Host side of the serial port: data, shift clock and strobe.
// Assumes one caller at a time; times are counted in falling edges of clk_in.
`timescale 1ns/1ps
module sdcp_host_model (
    input  logic clk_in,
    output logic sd_out,
    output logic sclk_out,
    output logic wrt_out
);
    initial begin
        sd_out = 1'b0;
        sclk_out = 1'b0;
        wrt_out = 1'b0;
    end
    // One 800 ns link period per bit; caller starts on a falling clock edge
    task automatic put_bit(input logic b);
        sd_out = b;
        repeat (2) @(negedge clk_in);
        sclk_out = 1'b1;
        repeat (4) @(negedge clk_in);
        sclk_out = 1'b0;
        @(negedge clk_in);
        sd_out = ~b;
        @(negedge clk_in);
    endtask
    task automatic put_frame(input logic [11:0] f);
        for (int i = 11; i >= 0; i--) put_bit(f[i]);
        repeat (4) @(negedge clk_in);
        wrt_out = 1'b1;
        repeat (4) @(negedge clk_in);
        wrt_out = 1'b0;
        repeat (8) @(negedge clk_in);
    endtask
endmodule

// [tb/sdcp_top_chk.sv]
// Assertions on the control port pins and outputs.
// Bound to every sdcp_top instance.
`timescale 1ns/1ps
module sdcp_top_chk
    import sdcp_pkg::*;
(
    input wire logic       clk_sys_in,
    input wire logic       reset_in,
    input wire logic       write_strobe_in,
    input wire logic       register_reset_n_in,
    input wire logic       reference_sample_pulse_n_in,
    input wire logic       dummy_clamp_pulse_n_in,
    input wire logic       black_clamp_pulse_n_in,
    input wire logic       output_latch_clock_in,
    input wire sdcp_pix_t  pixel_word_in,
    input wire sdcp_code_t attenuation_converter_out,
    input wire sdcp_code_t auxiliary_converter_out,
    input wire logic       input_clamp_out,
    input wire logic       black_loop_enable_out,
    input wire logic       dummy_loop_enable_out,
    input wire logic       sample_reference_out,
    input wire sdcp_pix_t  pixel_word_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    codes_clear_a: assert property (!register_reset_n_in |=>
        attenuation_converter_out == 10'h000 && auxiliary_converter_out == 10'h000)
        else $error("codes not cleared");
    codes_hold_a: assert property ((!write_strobe_in && register_reset_n_in)[*8] |=>
        $stable(attenuation_converter_out) && $stable(auxiliary_converter_out))
        else $error("code changed without strobe");
    one_target_a: assert property ($changed(attenuation_converter_out)
        && $past(register_reset_n_in) |-> $stable(auxiliary_converter_out))
        else $error("both codes changed");
    clamp_on_a: assert property ((!reference_sample_pulse_n_in
        && !dummy_clamp_pulse_n_in)[*7] |-> input_clamp_out) else $error("no clamp");
    black_follow_a: assert property ($stable(black_clamp_pulse_n_in)[*7]
        |-> black_loop_enable_out != black_clamp_pulse_n_in) else $error("black enable");
    dummy_follow_a: assert property ($stable(dummy_clamp_pulse_n_in)[*7]
        |-> dummy_loop_enable_out != dummy_clamp_pulse_n_in) else $error("dummy enable");
    ref_follow_a: assert property ($fell(reference_sample_pulse_n_in)
        |-> ##[1:6] sample_reference_out) else $error("reference sample late");
    latch_word_a: assert property ($rose(output_latch_clock_in)
        |-> ##[2:6] pixel_word_out == pixel_word_in) else $error("pixel word not latched");
    cover property ($changed(auxiliary_converter_out));
    cover property ($rose(input_clamp_out));
    cover property ($fell(register_reset_n_in));
endmodule
bind sdcp_top sdcp_top_chk u_chk (.*);

// [tb/serial_dac_control_port_bench.sv]
// Self-checking bench for sdcp_top with a host model on the serial pins.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ps
module serial_dac_control_port_bench;
    import sdcp_pkg::*;
    logic       clk_sys_in, reset_in, reg_rst_n, ref_n, pix_n, dum_n, blk_n, latch_clk;
    logic       sd, sclk, write_strobe, clamp, blk_en, dum_en, ref_s, pix_s, en;
    sdcp_pix_t  pix_word, pix_out;
    sdcp_code_t att, aux;
    int         bad_count = 0;
    int         checked = 0;
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    sdcp_host_model u_host (.clk_in(clk_sys_in), .sd_out(sd), .sclk_out(sclk), .wrt_out(write_strobe));
    sdcp_top u_dut (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .enable_in(en),
        .serial_data_in(sd), .serial_clock_in(sclk), .write_strobe_in(write_strobe),
        .register_reset_n_in(reg_rst_n), .reference_sample_pulse_n_in(ref_n),
        .pixel_sample_pulse_n_in(pix_n), .dummy_clamp_pulse_n_in(dum_n),
        .black_clamp_pulse_n_in(blk_n), .output_latch_clock_in(latch_clk),
        .pixel_word_in(pix_word), .attenuation_converter_out(att),
        .auxiliary_converter_out(aux), .input_clamp_out(clamp),
        .black_loop_enable_out(blk_en), .dummy_loop_enable_out(dum_en),
        .sample_reference_out(ref_s), .sample_pixel_out(pix_s), .pixel_word_out(pix_out)
    );
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_frames;
        u_host.put_frame({1'b1, 1'b0, 10'h2a5});
        chk(att, 10'h2a5);
        chk(aux, 10'h000);
        u_host.put_frame({1'b0, 1'b1, 10'h15a});
        chk(aux, 10'h15a);
        chk(att, 10'h2a5);
    endtask
    task automatic t_overrun;
        repeat (4) u_host.put_bit(1'b1);
        u_host.put_frame({1'b0, 1'b0, 10'h001});
        chk(att, 10'h001);
        chk(aux, 10'h15a);
    endtask
    task automatic t_freeze;
        en = 1'b0;
        u_host.put_frame({1'b0, 1'b1, 10'h3ff});
        chk(aux, 10'h15a);
        chk(att, 10'h001);
        en = 1'b1;
        repeat (4) @(negedge clk_sys_in);
    endtask
    task automatic t_reg_reset;
        reg_rst_n = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        chk(att, 10'h000);
        chk(aux, 10'h000);
        reg_rst_n = 1'b1;
        repeat (4) @(negedge clk_sys_in);
    endtask
    task automatic t_timing;
        ref_n = 1'b0;
        dum_n = 1'b0;
        pix_word = 10'h2c3;
        repeat (8) @(negedge clk_sys_in);
        chk({9'h000, clamp}, 10'h001);
        chk({9'h000, dum_en}, 10'h001);
        chk({9'h000, ref_s}, 10'h001);
        ref_n = 1'b1;
        pix_n = 1'b0;
        blk_n = 1'b0;
        latch_clk = 1'b1;
        repeat (8) @(negedge clk_sys_in);
        chk({9'h000, clamp}, 10'h000);
        chk({9'h000, blk_en}, 10'h001);
        chk({9'h000, pix_s}, 10'h001);
        chk(pix_out, 10'h2c3);
        latch_clk = 1'b0;
        pix_n = 1'b1;
        blk_n = 1'b1;
        dum_n = 1'b1;
    endtask
    initial begin
        reset_in = 1'b1;
        en = 1'b1;
        reg_rst_n = 1'b1;
        ref_n = 1'b1;
        pix_n = 1'b1;
        dum_n = 1'b1;
        blk_n = 1'b1;
        latch_clk = 1'b0;
        pix_word = 10'h000;
        repeat (8) @(negedge clk_sys_in);
        reset_in = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        chk(att, 10'h000);
        chk(aux, 10'h000);
        t_frames;
        t_overrun;
        t_freeze;
        t_reg_reset;
        t_timing;
        report_and_stop;
    end
    // Whole run is about 52 us
    initial begin
        #500000;
        bad_count++;
        report_and_stop;
    end
endmodule
